// *** core/lpr_pkg.sv ***
// Constants of the linear pixel readout sequencer.
// Assumes a single 40 MHz reference clock and synchronous inputs.
package lpr_pkg;
    localparam int PIXELS = 128;
    localparam int PIX_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_IDLE = 8'h00;
    localparam logic [CNT_W-1:0] CNT_FIRST = 8'h01;
    localparam logic [CNT_W-1:0] CNT_RESET_LAST = 8'h12;
    localparam logic [CNT_W-1:0] CNT_END = 8'h81;
    localparam logic [PIXELS-1:0] STAGE_FIRST = {{(PIXELS-1){1'b0}}, 1'b1};
    localparam logic [PIXELS-1:0] STAGE_NONE = '0;
    localparam logic [PIX_W-1:0] PIX_ZERO = 8'h00;
    // Pixel charge transfer time the host waits after edge 129, in ns.
    localparam int TQT_NS = 20000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TQT_CYCLES = (TQT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lpr_pkg

// *** core/lpr_sequencer.sv ***
// Readout sequencer of a 128-pixel linear sensor, with its sample FIFO.
// Assumes synchronous inputs on ref_clk; the pixel front end feeds samples in order.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module lpr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clocking.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Write side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Read side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_ptr_q];

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready <= 1'b0;
        end
        else if (clk_en)
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            in_ready <= (count_d != DEPTH[AW:0]);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (clk_en && push)
        begin
            mem[wr_ptr_q] <= in_data;
        end
    end
endmodule : lpr_fifo

////////////////////////////////////////////////////////////////////////////////
module lpr_sequencer (
    // Clocking.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Start pulse from the host.
    input wire logic serial_start,
    // Pixel samples from the front end.
    input wire logic sample_valid,
    input wire logic [lpr_pkg::PIX_W-1:0] sample_data,
    output logic sample_ready,
    // Array control.
    output logic hold_q,
    output logic integ_reset_q,
    output logic [lpr_pkg::PIXELS-1:0] stage_q,
    // Pixel output pin and status.
    output logic [lpr_pkg::PIX_W-1:0] analog_pixel_output_q,
    output logic analog_pixel_output_oe_q,
    output logic busy_q,
    output logic underrun_q
);
    import lpr_pkg::*;

    logic start_prev_q;
    logic [CNT_W-1:0] edge_cnt_q;
    logic start_take;
    logic advance;
    logic fifo_valid;
    logic [PIX_W-1:0] fifo_data;
    logic fifo_pop;

    // A start seen while a cycle runs is ignored.
    assign start_take = serial_start && !start_prev_q && !busy_q;
    assign advance = start_take || (stage_q[PIXELS-2:0] != '0);
    assign fifo_pop = advance;

    // The sender sees the FIFO's own ready flop, so every word accepted while clk_en is high is one it counted.
    lpr_fifo #(
        .WIDTH(PIX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .in_ready(sample_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            start_prev_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else if (clk_en)
        begin
            start_prev_q <= serial_start;
            hold_q <= start_take;
        end
    end

    // Shift register carrying the start pulse across the pixels.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            stage_q <= STAGE_NONE;
        end
        else if (clk_en)
        begin
            if (start_take)
            begin
                stage_q <= STAGE_FIRST;
            end
            else
            begin
                stage_q <= {stage_q[PIXELS-2:0], 1'b0};
            end
        end
    end

    // Edge count within the cycle: 1 at the start edge, 128 at the last; cleared on edge 129.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            edge_cnt_q <= CNT_IDLE;
            busy_q <= 1'b0;
            integ_reset_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_take)
            begin
                edge_cnt_q <= CNT_FIRST;
                busy_q <= 1'b1;
                integ_reset_q <= 1'b1;
            end
            else if (busy_q)
            begin
                edge_cnt_q <= edge_cnt_q + 1'b1;
                if (edge_cnt_q == CNT_RESET_LAST)
                begin
                    integ_reset_q <= 1'b0;
                end
                if (edge_cnt_q + 1'b1 == CNT_END)
                begin
                    busy_q <= 1'b0;
                    edge_cnt_q <= CNT_IDLE;
                end
            end
        end
    end

    // Output pin: driven only while a stage holds the pulse.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            analog_pixel_output_q <= PIX_ZERO;
            analog_pixel_output_oe_q <= 1'b0;
            underrun_q <= 1'b0;
        end
        else if (clk_en)
        begin
            analog_pixel_output_oe_q <= advance;
            if (advance && fifo_valid)
            begin
                analog_pixel_output_q <= fifo_data;
            end
            else if (!advance)
            begin
                analog_pixel_output_q <= PIX_ZERO;
            end
            if (start_take)
            begin
                underrun_q <= !fifo_valid;
            end
            else if (advance && !fifo_valid)
            begin
                underrun_q <= 1'b1;
            end
        end
    end
endmodule : lpr_sequencer

// *** tb/lpr_sequencer_properties.sv ***
// Port checker of the readout sequencer.
// Assumes it is bound to lpr_sequencer and sees only its ports.
`timescale 1ns/1ps
module lpr_chk
    import lpr_pkg::*;
(
    // Watched ports.
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic serial_start,
    input wire logic hold_q,
    input wire logic integ_reset_q,
    input wire logic [lpr_pkg::PIXELS-1:0] stage_q,
    input wire logic analog_pixel_output_oe_q,
    input wire logic busy_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    // A frozen cycle voids every attempt that spans it.
    default disable iff (reset || !clk_en);
    sequence start_seen;
        serial_start && !$past(serial_start) && !busy_q;
    endsequence
    sequence frame_open;
        hold_q && busy_q && analog_pixel_output_oe_q && stage_q == STAGE_FIRST;
    endsequence
    start_take_a: assert property (start_seen |=> frame_open) else $error("start lost");
    hold_pulse_a: assert property (hold_q |=> !hold_q && integ_reset_q) else $error("hold");
    stage_walk_a: assert property (busy_q && !stage_q[PIXELS-1] |=>
        stage_q == $past(stage_q) << 1) else $error("stage walk");
    integ_span_a: assert property (integ_reset_q == (|stage_q[17:0])) else $error("integ");
    frame_end_a: assert property (stage_q[PIXELS-1] |=>
        !busy_q && !analog_pixel_output_oe_q && stage_q == STAGE_NONE) else $error("end");
    oe_span_a: assert property (analog_pixel_output_oe_q == busy_q) else $error("oe");
    busy_refuse_a: assert property (busy_q && serial_start && !stage_q[PIXELS-1] |=>
        !hold_q && busy_q && stage_q != STAGE_FIRST) else $error("restart");
endmodule : lpr_chk

bind lpr_sequencer lpr_chk chk_u (.ref_clk, .reset, .clk_en, .serial_start, .hold_q,
    .integ_reset_q, .stage_q, .analog_pixel_output_oe_q, .busy_q);

// *** tb/lpr_host_model.sv ***
// Host model: start pulse source and pixel sample feeder.
// Assumes the bench moves go and feed just after a rising edge.
`timescale 1ns/1ps
module lpr_host
    import lpr_pkg::*;
(
    // Bench control.
    input wire logic ref_clk,
    input wire logic go,
    input wire logic feed,
    // Sequencer side.
    output logic serial_start,
    output logic sample_valid,
    output logic [lpr_pkg::PIX_W-1:0] sample_data,
    input wire logic sample_ready
);
    logic [PIX_W-1:0] count_q = PIX_ZERO;
    logic start_q = 1'b0;
    always @(posedge ref_clk) start_q <= go;
    always @(posedge ref_clk) if (feed && sample_ready) count_q <= count_q + 1'b1;
    assign serial_start = start_q;
    assign sample_valid = feed;
    // Idle data shows the inverse so a stale word cannot pass as new.
    assign sample_data = feed ? count_q : ~count_q;
endmodule : lpr_host

// *** tb/test_lpr_sequencer.sv ***
// Bench of the readout sequencer driven through the host model.
// Assumes the package constants; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
module test_lpr_sequencer;
    import lpr_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    logic feed = 1'b0;
    logic en = 1'b1;
    logic serial_start, sample_valid, sample_ready, hold_q, integ_reset_q, oe, busy_q, underrun_q;
    logic [PIX_W-1:0] sample_data, pix;
    logic [PIX_W-1:0] next_word = PIX_ZERO;
    logic [PIXELS-1:0] stage_q;
    int fails = 0;
    int samples_checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    lpr_host host_u (.ref_clk, .go, .feed, .serial_start, .sample_valid, .sample_data,
        .sample_ready);
    lpr_sequencer dut_u (.ref_clk, .reset, .clk_en(en), .serial_start, .sample_valid,
        .sample_data, .sample_ready, .hold_q, .integ_reset_q, .stage_q,
        .analog_pixel_output_q(pix), .analog_pixel_output_oe_q(oe), .busy_q, .underrun_q);
    task automatic final_report;
        $display("Checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input logic [PIX_W-1:0] got, input logic [PIX_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Fills the FIFO with the sequencer idle until it refuses.
    task automatic fill_test;
        int i;
        feed = 1'b1;
        for (i = 0; i < 24 && sample_ready !== 1'b0; i++)
            tick(1);
        chk(i >= 16 && i < 20, 1'b1);
        feed = 1'b0;
        if (i == 24)
            final_report();
        $display("fill done");
    endtask : fill_test
    // One frame: f feeds samples, w is the start width, mid is when a stray start comes.
    task automatic frame(input logic f, input int w, input int mid);
        int i;
        int n;
        feed = f;
        tick(8);
        go = 1'b1;
        tick(1);
        // A two-clock start stays high over the taking edge and drops in the loop below.
        go = (w > 1);
        for (i = 0; i < 4 && busy_q !== 1'b1; i++)
            tick(1);
        chk(busy_q, 1'b1);
        chk(hold_q, 1'b1);
        if (busy_q !== 1'b1)
            final_report();
        for (n = 0; n < 200 && busy_q === 1'b1; n++)
        begin
            chk(integ_reset_q, n < 18);
            if (f)
                chk(pix, PIX_W'(next_word + n));
            go = (n == mid);
            if (f && n == 90)
            begin
                // Clock enable low must freeze the walk; feeding pauses with it.
                en = 1'b0;
                feed = 1'b0;
                tick(3);
                chk(stage_q[n], 1'b1);
                chk(pix, PIX_W'(next_word + n));
                feed = 1'b1;
                en = 1'b1;
            end
            tick(1);
        end
        chk(PIX_W'(n), 8'h80);
        chk({oe, underrun_q}, {1'b0, !f});
        chk(pix, PIX_ZERO);
        chk(stage_q == STAGE_NONE, 1'b1);
        feed = 1'b0;
        // A fed frame pops one word per pixel; the dummy frame drains the filled FIFO.
        next_word = PIX_W'(next_word + (f ? PIXELS : FIFO_DEPTH));
        if (n == 200)
            final_report();
        tick(TQT_CYCLES);
        $display("frame done");
    endtask : frame
    initial
    begin
        tick(3);
        reset = 1'b0;
        tick(2);
        fill_test();
        frame(1'b0, 1, -1);
        frame(1'b1, 1, 50);
        frame(1'b1, 2, -1);
        final_report();
    end
endmodule : test_lpr_sequencer
